// ==== core/pdbc_byte_counter.sv ====
`default_nettype none

module pdbc_byte_counter (
  input wire logic clk,
  input wire logic arst_n,
  input wire pdbc_pkg::pdbc_host_req_t hostReq,
  output logic [7:0] rdData,
  output logic rdValid,
  input wire logic dmaEnableBit,
  input wire logic countEndEnable,
  input wire logic byteMoved,
  output logic [15:0] remainingCount,
  output logic transferActive,
  output logic endOfTransfer
);
  import pdbc_pkg::*;

  // ----------------------------------------
  // access sequencer state
  // ----------------------------------------
  pdbc_seq_t stateReg;               // where in a two byte access we are
  pdbc_seq_t stateNext;
  logic [7:0] lowByteReg;            // first write byte, held until second
  logic [7:0] lowByteNext;
  logic [15:0] byteCountReg;         // programmed transfer length
  logic [15:0] byteCountNext;
  logic [15:0] snapReg;              // remaining count frozen at read command
  logic [15:0] snapNext;
  logic [7:0] rdDataReg;             // byte handed back to the processor
  logic [7:0] rdDataNext;
  logic rdValidReg;                  // one cycle read answer marker
  logic rdValidNext;

  // ----------------------------------------
  // transfer control state
  // ----------------------------------------
  logic activeReg;                   // a dma transfer is running
  logic activeNext;
  logic xferEndReg;                  // end of transfer pulse
  logic xferEndNext;
  logic enableDlyReg;                // enable one cycle ago, for edge detect
  logic [15:0] workCount;            // working down-counter value
  logic loadWork;                    // reload working counter
  logic decWork;                     // one byte moved this cycle
  logic lastByte;                    // this byte empties the counter

  // ----------------------------------------
  // command decode and byte pairing
  // ----------------------------------------
  // a new command always restarts the sequence, so a short access is
  // abandoned rather than mixed with the next one
  always_comb begin
    stateNext = stateReg;
    lowByteNext = lowByteReg;
    byteCountNext = byteCountReg;
    snapNext = snapReg;
    rdDataNext = rdDataReg;
    rdValidNext = 1'b0;
    if (hostReq.cmdStrobe) begin
      case (hostReq.data)
        CMD_WRITE_COUNT: begin
          stateNext = SEQ_WR_LO;
        end
        CMD_READ_COUNT: begin
          // snapshot so both bytes come from the same count
          snapNext = workCount;
          stateNext = SEQ_RD_LO;
        end
        default: begin
          // codes of other registers are not ours
          stateNext = SEQ_IDLE;
        end
      endcase
    end else begin
      case (stateReg)
        SEQ_WR_LO: begin
          if (hostReq.wrStrobe) begin
            lowByteNext = hostReq.data;
            stateNext = SEQ_WR_HI;
          end
        end
        SEQ_WR_HI: begin
          if (hostReq.wrStrobe) begin
            // commit only with the second byte: full field at once
            byteCountNext = {hostReq.data, lowByteReg};
            stateNext = SEQ_IDLE;
          end
        end
        SEQ_RD_LO: begin
          if (hostReq.rdStrobe) begin
            rdDataNext = snapReg[LOW_BYTE_LSB +: 8];
            rdValidNext = 1'b1;
            stateNext = SEQ_RD_HI;
          end
        end
        SEQ_RD_HI: begin
          if (hostReq.rdStrobe) begin
            rdDataNext = snapReg[HIGH_BYTE_LSB +: 8];
            rdValidNext = 1'b1;
            stateNext = SEQ_IDLE;
          end
        end
        default: begin
          // idle: stray strobes are ignored, a third byte included
          stateNext = SEQ_IDLE;
        end
      endcase
    end
  end

  // register only; no bus reset input exists, so the count
  // survives a usb bus reset and only arst_n clears it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stateReg <= SEQ_IDLE;
      lowByteReg <= BYTE_RESET;
      byteCountReg <= COUNT_RESET;
      snapReg <= COUNT_RESET;
      rdDataReg <= BYTE_RESET;
      rdValidReg <= 1'b0;
    end else begin
      stateReg <= stateNext;
      lowByteReg <= lowByteNext;
      byteCountReg <= byteCountNext;
      snapReg <= snapNext;
      rdDataReg <= rdDataNext;
      rdValidReg <= rdValidNext;
    end
  end

  // ----------------------------------------
  // transfer control
  // ----------------------------------------
  // start of each transfer reloads, so software writes the length once
  assign loadWork = dmaEnableBit && !enableDlyReg;
  // enable gates directly: the count freezes the very cycle it drops
  assign decWork = activeReg && dmaEnableBit && byteMoved && !loadWork;
  assign lastByte = decWork && (workCount == COUNT_ONE);

  // next transfer state and end pulse
  always_comb begin
    activeNext = activeReg;
    xferEndNext = 1'b0;
    if (loadWork) begin
      activeNext = 1'b1;
    end else if (!dmaEnableBit) begin
      activeNext = 1'b0;
    end else if (lastByte && countEndEnable) begin
      // without count end the transfer just idles at zero
      activeNext = 1'b0;
      xferEndNext = 1'b1;
    end
  end

  // register only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      activeReg <= 1'b0;
      xferEndReg <= 1'b0;
      enableDlyReg <= 1'b0;
    end else begin
      activeReg <= activeNext;
      xferEndReg <= xferEndNext;
      enableDlyReg <= dmaEnableBit;
    end
  end

  // ----------------------------------------
  // working counter
  // ----------------------------------------
  pdbc_down_counter #(
    .WIDTH(COUNT_WIDTH)
  ) uWork (
    .clk(clk),
    .arst_n(arst_n),
    .load(loadWork),
    .loadValue(byteCountReg),
    .dec(decWork),
    .count(workCount)
  );

  // ----------------------------------------
  // outputs, all from flops
  // ----------------------------------------
  assign rdData = rdDataReg;
  assign rdValid = rdValidReg;
  assign remainingCount = workCount;
  assign transferActive = activeReg;
  assign endOfTransfer = xferEndReg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_write_commit;
    @(posedge clk) disable iff (!arst_n)
    (stateReg == SEQ_WR_HI && hostReq.wrStrobe && !hostReq.cmdStrobe)
      |=> (byteCountReg == {$past(hostReq.data), $past(lowByteReg)});
  endproperty
  a_write_commit: assert property (p_write_commit) else $error("count write not committed");

  property p_read_snapshot;
    @(posedge clk) disable iff (!arst_n)
    (hostReq.cmdStrobe && hostReq.data == CMD_READ_COUNT) |=> (snapReg == $past(workCount));
  endproperty
  a_read_snapshot: assert property (p_read_snapshot) else $error("read snapshot wrong");

  property p_read_low;
    @(posedge clk) disable iff (!arst_n)
    (stateReg == SEQ_RD_LO && hostReq.rdStrobe && !hostReq.cmdStrobe)
      |=> (rdValid && rdData == $past(snapReg[7:0]));
  endproperty
  a_read_low: assert property (p_read_low) else $error("low read byte wrong");

  property p_two_bytes;
    @(posedge clk) disable iff (!arst_n)
    (hostReq.cmdStrobe && hostReq.data == CMD_WRITE_COUNT)
      ##1 (!hostReq.cmdStrobe && hostReq.wrStrobe) |=> (stateReg == SEQ_WR_HI);
  endproperty
  a_two_bytes: assert property (p_two_bytes) else $error("second byte not awaited");

  property p_read_high;
    @(posedge clk) disable iff (!arst_n)
    (stateReg == SEQ_RD_HI && hostReq.rdStrobe && !hostReq.cmdStrobe)
      |=> (rdValid && rdData == $past(snapReg[15:8]) && stateReg == SEQ_IDLE);
  endproperty
  a_read_high: assert property (p_read_high) else $error("high read byte wrong");

  property p_reload;
    @(posedge clk) disable iff (!arst_n)
    $rose(dmaEnableBit) |=> (workCount == $past(byteCountReg) && transferActive);
  endproperty
  a_reload: assert property (p_reload) else $error("working counter not reloaded");

  property p_xfer_end;
    @(posedge clk) disable iff (!arst_n)
    (activeReg && dmaEnableBit && byteMoved && countEndEnable && !loadWork && workCount == COUNT_ONE)
      |=> (endOfTransfer && workCount == COUNT_RESET) ##1 !endOfTransfer;
  endproperty
  a_xfer_end: assert property (p_xfer_end) else $error("end of transfer missing");

  property p_freeze;
    @(posedge clk) disable iff (!arst_n)
    (!dmaEnableBit) [*2] |-> $stable(workCount) && !transferActive;
  endproperty
  a_freeze: assert property (p_freeze) else $error("count moved while disabled");

  property p_decrement;
    @(posedge clk) disable iff (!arst_n)
    (activeReg && dmaEnableBit && byteMoved && !loadWork && workCount != COUNT_RESET)
      |=> (workCount == 16'($past(workCount) - COUNT_ONE));
  endproperty
  a_decrement: assert property (p_decrement) else $error("counter did not decrement");

endmodule

`default_nettype wire

// ==== core/pdbc_pkg.sv ====
// Operation
// - F2 stores the next transfer byte count
// - F3 returns bytes still remaining, not programmed
// - one command code, then exactly two bytes
// - count is full sixteen bits, read/write
// - usb bus reset keeps count; device reset clears
// - working counter reloads from programmed count automatically
// - count end enable raises end of transfer
// - clearing dma enable freezes the remaining count
`default_nettype none

package pdbc_pkg;

  // ----------------------------------------
  // command codes and field layout
  // ----------------------------------------
  localparam int COUNT_WIDTH = 16;              // byte count field width
  localparam logic [7:0] CMD_WRITE_COUNT = 8'hF2; // load byte count
  localparam logic [7:0] CMD_READ_COUNT = 8'hF3;  // read remaining bytes
  localparam int LOW_BYTE_LSB = 0;              // first data byte position
  localparam int HIGH_BYTE_LSB = 8;             // second data byte position

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] COUNT_RESET = 16'h0000; // programmed and working count
  localparam logic [7:0] BYTE_RESET = 8'h00;      // byte holding registers
  localparam logic [15:0] COUNT_ONE = 16'h0001;   // last byte of a transfer

  // ----------------------------------------
  // carried types
  // ----------------------------------------
  // one cycle of the microprocessor command/data port
  typedef struct packed {
    logic cmdStrobe;   // command phase, data holds the code
    logic wrStrobe;    // data write phase
    logic rdStrobe;    // data read phase
    logic [7:0] data;  // code or write data
  } pdbc_host_req_t;

  // access sequencer states
  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_WR_LO,
    SEQ_WR_HI,
    SEQ_RD_LO,
    SEQ_RD_HI
  } pdbc_seq_t;

endpackage

`default_nettype wire

// ==== core/pdbc_down_counter.sv ====
`default_nettype none

module pdbc_down_counter #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  input wire logic dec,
  output var logic [WIDTH-1:0] count
);

  // ----------------------------------------
  // working counter
  // ----------------------------------------
  logic [WIDTH-1:0] countReg;   // remaining bytes
  logic [WIDTH-1:0] countNext;  // next remaining bytes

  // load beats decrement so a fresh transfer starts clean
  always_comb begin
    countNext = countReg;
    if (load) begin
      countNext = loadValue;
    end else if (dec && (countReg != '0)) begin
      // saturates at zero, never wraps
      countNext = countReg - WIDTH'(1);
    end
  end

  // register only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      countReg <= '0;
    end else begin
      countReg <= countNext;
    end
  end

  assign count = countReg;

endmodule

`default_nettype wire

// ==== tb/pdbc_dma_partner.sv ====
`default_nettype none

module pdbc_dma_partner (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic stall,
  input wire logic transferActive,
  output logic byteMoved
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // dma controller moving bytes
  // ----------------------------------------
  // one byte per cycle while active, unless stalled; a slow controller
  // shows up as random stall cycles
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      byteMoved <= 1'b0;
    end else begin
      byteMoved <= transferActive && !stall;
    end
  end
endmodule

`default_nettype wire

// ==== tb/tb_peripheral_dma_byte_counter.sv ====
`default_nettype none

`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t mismatch %h vs %h", $time, a, b); end end

module tb_peripheral_dma_byte_counter;
  timeunit 1ns;
  timeprecision 1ns;
  import pdbc_pkg::*;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  pdbc_host_req_t hostReq = '0;
  logic dmaOn = 1'b0;
  logic cee = 1'b0;
  logic stall = 1'b0;
  logic byteMoved, rdValid, transferActive, endOfTransfer;
  logic [7:0] rdData;
  logic [15:0] remainingCount;
  logic [15:0] v;
  int seed = 97625;
  int error_cnt = 0;
  int comparisons = 0;
  int mProg = 0; // count as software last committed it
  int mCnt = 0; // working counter of the model
  logic mAct = 1'b0;
  logic mEnd = 1'b0;
  logic enPrev = 1'b0;

  always #20 clk = ~clk;
  always @(posedge clk) stall <= 1'($random(seed));

  pdbc_byte_counter i_dut (.clk(clk), .arst_n(arst_n), .hostReq(hostReq), .rdData(rdData),
    .rdValid(rdValid), .dmaEnableBit(dmaOn), .countEndEnable(cee), .byteMoved(byteMoved),
    .remainingCount(remainingCount), .transferActive(transferActive), .endOfTransfer(endOfTransfer));
  pdbc_dma_partner i_dma (.clk(clk), .arst_n(arst_n), .stall(stall),
    .transferActive(transferActive), .byteMoved(byteMoved));

  // ----------------------------------------
  // reference model of the transfer side
  // ----------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mCnt <= 0;
      mAct <= 1'b0;
      mEnd <= 1'b0;
      enPrev <= 1'b0;
    end else begin
      enPrev <= dmaOn;
      mEnd <= 1'b0;
      if (dmaOn && !enPrev) begin
        mCnt <= mProg;
        mAct <= 1'b1;
      end else if (!dmaOn) begin
        mAct <= 1'b0;
      end else if (mAct && byteMoved && mCnt != 0) begin
        mCnt <= mCnt - 1;
        if (mCnt == 1 && cee) begin
          mEnd <= 1'b1;
          mAct <= 1'b0;
        end
      end
    end
  end

  // compared mid-cycle, where registered outputs have settled
  always @(negedge clk) begin
    `CHK(remainingCount, 16'(mCnt))
    `CHK(transferActive, mAct)
    `CHK(endOfTransfer, mEnd)
  end

  // ----------------------------------------
  // host port and dma control tasks
  // ----------------------------------------
  task put(input logic c, input logic w, input logic r, input logic [7:0] d);
    @(posedge clk);
    hostReq <= '{cmdStrobe: c, wrStrobe: w, rdStrobe: r, data: d};
  endtask

  // the host always hands over both bytes, low first
  task wrCount(input logic [15:0] val);
    put(1'b1, 1'b0, 1'b0, CMD_WRITE_COUNT);
    put(1'b0, 1'b1, 1'b0, val[7:0]);
    put(1'b0, 1'b1, 1'b0, val[15:8]);
    put(1'b0, 1'b0, 1'b0, 8'h00);
    mProg = val;
  endtask

  task rdCount(input logic [15:0] exp);
    put(1'b1, 1'b0, 1'b0, CMD_READ_COUNT);
    put(1'b0, 1'b0, 1'b1, 8'h00);
    put(1'b0, 1'b0, 1'b1, 8'h00);
    #1;
    `CHK(rdValid, 1'b1)
    `CHK(rdData, exp[7:0])
    put(1'b0, 1'b0, 1'b0, 8'h00);
    #1;
    `CHK(rdValid, 1'b1)
    `CHK(rdData, exp[15:8])
  endtask

  task startRun(input logic endEn);
    @(posedge clk);
    cee <= endEn;
    dmaOn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task stop;
    @(posedge clk);
    dmaOn <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task tally_and_finish;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rdCount(16'h0000);
    // short runs to zero, the first of a single byte
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 16'h0001 : 16'(1 + {$random(seed)} % 24);
      wrCount(v);
      startRun(1'b1);
      for (int i = 0; i < 400 && transferActive !== 1'b0; i++) begin
        @(posedge clk);
        #1;
      end
      `CHK(remainingCount, 16'h0000)
      stop();
    end
    // wide value, cut short: read gives the frozen remainder
    v = 16'($random(seed)) | 16'h8001;
    wrCount(v);
    startRun(1'b1);
    repeat (10) @(posedge clk);
    stop();
    rdCount(16'(mCnt));
    // abandoned half write, then restart reloads the old count
    put(1'b1, 1'b0, 1'b0, CMD_WRITE_COUNT);
    put(1'b0, 1'b1, 1'b0, 8'h5A);
    put(1'b1, 1'b0, 1'b0, 8'h00);
    put(1'b0, 1'b0, 1'b0, 8'h00);
    startRun(1'b1);
    // no byte can move before the edge after the reload
    `CHK(remainingCount, 16'(mProg))
    stop();
    rdCount(16'(mCnt));
    // no end-of-count flag: parks at zero, still active
    wrCount(16'h0003);
    startRun(1'b0);
    repeat (30) @(posedge clk);
    #1;
    `CHK(transferActive, 1'b1)
    // device reset in mid-run, enable still high: the restart after
    // release must reload zero, so the programmed count was cleared
    @(posedge clk);
    arst_n <= 1'b0;
    mProg = 0;
    @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK(transferActive, 1'b1)
    `CHK(remainingCount, 16'h0000)
    stop();
    rdCount(16'h0000);
    tally_and_finish();
  end

  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
